/* xmia_top.sv */
/*
 * Extended memory indirect access window in the primary register space.
 * The serial front end (i2c, spi or manchester) presents byte reads and
 * writes at primary byte addresses; the processor services the commands.
 * Assumes front end strobes are on CLK_SYS_IN; processor status levels
 * arrive from another domain and are synchronised here.
 */
`timescale 1ns/1ps
`include "xmia_defs.svh"
module xmia_top
   import xmia_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic NRST_IN,
   // primary register byte port from the serial front end
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   output logic [7:0] REG_RDATA_OUT,
   output logic REG_HIT_OUT,
   // device mode
   input wire logic IDLE_MODE_IN,
   // processor side
   input wire logic PROC_SLOT_IN,
   input wire logic PROC_FINISH_IN,
   input wire logic [31:0] PROC_RESULT_IN,
   output logic PROC_WR_CMD_OUT,
   output logic PROC_RD_CMD_OUT,
   output logic [15:0] PROC_ADDR_OUT,
   output logic [31:0] PROC_WDATA_OUT,
   output logic PROC_IDLE_OUT,
   output logic CMD_LATE_OUT
);
   typedef struct packed {
      logic [15:0] wr_addr_ff;
      logic [31:0] wr_data_ff;
      logic [15:0] rd_addr_ff;
      logic [31:0] rd_result_ff;
      logic [31:0] res_s1_ff;
      logic [31:0] res_s2_ff;
      logic wr_done_ff;
      logic rd_done_ff;
      logic cmd_is_rd_ff;
      logic [15:0] cmd_addr_ff;
      logic [31:0] cmd_data_ff;
      logic [7:0] rdata_ff;
   } xmia_top_s;

   xmia_top_s st_ff;
   xmia_top_s nxt_st;

   logic slot_sync;
   logic finish_sync;
   logic idle_sync;
   logic seq_start;
   logic seq_busy;
   logic seq_done;
   logic seq_issue;
   logic seq_late;
   logic wr_trig;
   logic rd_trig;

   // ==========================================================
   // synchronisers for processor and mode levels
   xmia_sync u_sync_slot (
      .clk_in(CLK_SYS_IN),
      .nrst_in(NRST_IN),
      .d_in(PROC_SLOT_IN),
      .q_out(slot_sync)
   );
   xmia_sync u_sync_fin (
      .clk_in(CLK_SYS_IN),
      .nrst_in(NRST_IN),
      .d_in(PROC_FINISH_IN),
      .q_out(finish_sync)
   );
   xmia_sync u_sync_idle (
      .clk_in(CLK_SYS_IN),
      .nrst_in(NRST_IN),
      .d_in(IDLE_MODE_IN),
      .q_out(idle_sync)
   );

   // ==========================================================
   // decode
   function automatic logic is_adr(input logic [7:0] a,
                                   input logic [7:0] b);
      is_adr = (a == b);
   endfunction

   function automatic logic in_range(input logic [7:0] a,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // byte lane of a big-endian word: lowest address is the top byte
   function automatic logic [1:0] lane(input logic [7:0] a,
                                       input logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      lane = 2'(2'd3 - d[1:0]); // R13
   endfunction

   assign wr_trig = REG_WR_IN && is_adr(REG_ADDR_IN, `XMIA_ADR_WCS_HI)
                    && REG_WDATA_IN[`XMIA_EXEC_BIT]; // R5
   assign rd_trig = REG_WR_IN && is_adr(REG_ADDR_IN, `XMIA_ADR_RCS_HI)
                    && REG_WDATA_IN[`XMIA_EXEC_BIT]; // R10
   // a trigger while busy is dropped: the host must wait for done
   assign seq_start = (wr_trig || rd_trig) && !seq_busy; // R18

   xmia_seq u_seq (
      .clk_in(CLK_SYS_IN),
      .nrst_in(NRST_IN),
      .start_in(seq_start),
      .busy_out(seq_busy),
      .done_out(seq_done),
      .timeout_out(seq_late),
      .slot_in(slot_sync),
      .finish_in(finish_sync),
      .issue_out(seq_issue)
   );

   // ==========================================================
   // register writes and command capture
   always_comb begin
      logic [1:0] ln;
      ln = 2'b00;
      nxt_st = st_ff;
      // result word crosses domains: two stages before the capture
      // flop, qualified by the synchronised finish level
      nxt_st.res_s1_ff = PROC_RESULT_IN;
      nxt_st.res_s2_ff = st_ff.res_s1_ff;
      // one map for every front end; the byte port is shared
      if (REG_WR_IN) begin // R15
         if (is_adr(REG_ADDR_IN, `XMIA_ADR_WA_HI)) begin
            nxt_st.wr_addr_ff[15:8] = REG_WDATA_IN; // R3
         end
         if (is_adr(REG_ADDR_IN, `XMIA_ADR_WA_LO)) begin
            nxt_st.wr_addr_ff[7:0] = REG_WDATA_IN; // R3
         end
         if (in_range(REG_ADDR_IN, `XMIA_ADR_WD_0, `XMIA_ADR_WD_3)) begin
            ln = lane(REG_ADDR_IN, `XMIA_ADR_WD_0);
            nxt_st.wr_data_ff[ln*8 +: 8] = REG_WDATA_IN; // R4
         end
         if (is_adr(REG_ADDR_IN, `XMIA_ADR_RA_HI)) begin
            nxt_st.rd_addr_ff[15:8] = REG_WDATA_IN; // R9
         end
         if (is_adr(REG_ADDR_IN, `XMIA_ADR_RA_LO)) begin
            nxt_st.rd_addr_ff[7:0] = REG_WDATA_IN; // R9
         end
      end
      // snapshot at trigger so later bank writes do not corrupt it
      if (seq_start) begin
         nxt_st.cmd_is_rd_ff = rd_trig;
         nxt_st.cmd_addr_ff = rd_trig ? st_ff.rd_addr_ff
                                      : st_ff.wr_addr_ff; // R1
         nxt_st.cmd_data_ff = st_ff.wr_data_ff; // R1
      end
      // done set on finish; execute clears done (set wins; busy is already
      // low in the done cycle, so the two can land in the same cycle)
      if (seq_start && wr_trig) begin
         nxt_st.wr_done_ff = 1'b0; // R19
      end
      if (seq_start && rd_trig) begin
         nxt_st.rd_done_ff = 1'b0; // R19
      end
      if (seq_done && !st_ff.cmd_is_rd_ff) begin
         nxt_st.wr_done_ff = 1'b1; // R7
      end
      if (seq_done && st_ff.cmd_is_rd_ff) begin
         nxt_st.rd_done_ff = 1'b1; // R11
         nxt_st.rd_result_ff = st_ff.res_s2_ff; // R12
      end
      // ======================================================
      // read data, one byte per strobe; pointer kept by front end
      if (REG_RD_IN) begin // R16
         nxt_st.rdata_ff = `XMIA_RST_BYTE;
         if (is_adr(REG_ADDR_IN, `XMIA_ADR_WA_HI)) begin
            nxt_st.rdata_ff = st_ff.wr_addr_ff[15:8];
         end
         if (is_adr(REG_ADDR_IN, `XMIA_ADR_WA_LO)) begin
            nxt_st.rdata_ff = st_ff.wr_addr_ff[7:0];
         end
         if (in_range(REG_ADDR_IN, `XMIA_ADR_WD_0, `XMIA_ADR_WD_3)) begin
            ln = lane(REG_ADDR_IN, `XMIA_ADR_WD_0);
            nxt_st.rdata_ff = st_ff.wr_data_ff[ln*8 +: 8]; // R13
         end
         if (is_adr(REG_ADDR_IN, `XMIA_ADR_WCS_HI)) begin
            nxt_st.rdata_ff[`XMIA_EXEC_BIT] =
               seq_busy && !st_ff.cmd_is_rd_ff;
         end
         if (is_adr(REG_ADDR_IN, `XMIA_ADR_WCS_LO)) begin
            nxt_st.rdata_ff[`XMIA_DONE_BIT] = st_ff.wr_done_ff; // R7
         end
         if (is_adr(REG_ADDR_IN, `XMIA_ADR_RA_HI)) begin
            nxt_st.rdata_ff = st_ff.rd_addr_ff[15:8];
         end
         if (is_adr(REG_ADDR_IN, `XMIA_ADR_RA_LO)) begin
            nxt_st.rdata_ff = st_ff.rd_addr_ff[7:0];
         end
         if (is_adr(REG_ADDR_IN, `XMIA_ADR_RCS_HI)) begin
            nxt_st.rdata_ff[`XMIA_EXEC_BIT] =
               seq_busy && st_ff.cmd_is_rd_ff;
         end
         if (is_adr(REG_ADDR_IN, `XMIA_ADR_RCS_LO)) begin
            nxt_st.rdata_ff[`XMIA_DONE_BIT] = st_ff.rd_done_ff; // R11
         end
         if (in_range(REG_ADDR_IN, `XMIA_ADR_RD_0, `XMIA_ADR_RD_3)) begin
            ln = lane(REG_ADDR_IN, `XMIA_ADR_RD_0);
            nxt_st.rdata_ff = st_ff.rd_result_ff[ln*8 +: 8]; // R12
         end
      end
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (!NRST_IN) begin
         st_ff <= '{`XMIA_RST_ADDR, `XMIA_RST_WORD, `XMIA_RST_ADDR,
                    `XMIA_RST_WORD, `XMIA_RST_WORD, `XMIA_RST_WORD,
                    1'b0, 1'b0, 1'b0, `XMIA_RST_ADDR,
                    `XMIA_RST_WORD, `XMIA_RST_BYTE};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // outputs
   assign REG_RDATA_OUT = st_ff.rdata_ff; // R14
   assign REG_HIT_OUT = in_range(REG_ADDR_IN, `XMIA_ADR_WA_HI,
                                 `XMIA_ADR_RD_3);
   assign PROC_WR_CMD_OUT = seq_issue && !st_ff.cmd_is_rd_ff;
   assign PROC_RD_CMD_OUT = seq_issue && st_ff.cmd_is_rd_ff;
   assign PROC_ADDR_OUT = st_ff.cmd_addr_ff;
   assign PROC_WDATA_OUT = st_ff.cmd_data_ff;
   // processor decides eeprom legality from this mode level
   assign PROC_IDLE_OUT = idle_sync; // R2
   assign CMD_LATE_OUT = seq_late;
endmodule

/* xmia_defs.svh */
/*
 * Constants for the extended memory indirect access window: primary
 * register byte addresses, control bit positions and timing counts.
 * Assumes a single 100 MHz system clock.
 */
// Contract
// [R1] host loads write address, then data, then triggers
// [R2] idle mode gates eeprom and some configuration access
// [R3] write address at 0x02 upper, 0x03 lower
// [R4] write data 0x04..0x07, msb at lowest
// [R5] byte 0x80 to 0x08 starts write
// [R6] host sends eeprom programming pulses after trigger
// [R7] write done flag is bit 0 at 0x09
// [R8] host loads read address, triggers, then reads result
// [R9] read address at 0x0A upper, 0x0B lower
// [R10] byte 0x80 to 0x0C starts read
// [R11] read done flag is bit 0 at 0x0D
// [R12] read result 0x0E..0x11, msb at 0x0E
// [R13] multi-byte registers big endian by address
// [R14] same map for i2c, spi and manchester
// [R15] pointer auto-increments per written data byte
// [R16] read sequence streams status then result bytes
// [R17] command accepted between angle computations, within 128us
// [R18] host waits for completion before next trigger
// [R19] execute clears done; done set on finish
`ifndef XMIA_DEFS_SVH
`define XMIA_DEFS_SVH

// ==========================================================
// register byte addresses
`define XMIA_ADR_WA_HI 8'h02
`define XMIA_ADR_WA_LO 8'h03
`define XMIA_ADR_WD_0 8'h04
`define XMIA_ADR_WD_3 8'h07
`define XMIA_ADR_WCS_HI 8'h08
`define XMIA_ADR_WCS_LO 8'h09
`define XMIA_ADR_RA_HI 8'h0A
`define XMIA_ADR_RA_LO 8'h0B
`define XMIA_ADR_RCS_HI 8'h0C
`define XMIA_ADR_RCS_LO 8'h0D
`define XMIA_ADR_RD_0 8'h0E
`define XMIA_ADR_RD_3 8'h11

// ==========================================================
// fields and reset values
`define XMIA_EXEC_BIT 7
`define XMIA_DONE_BIT 0
`define XMIA_RST_BYTE 8'h00
`define XMIA_RST_WORD 32'h0000_0000
`define XMIA_RST_ADDR 16'h0000

// ==========================================================
// timing
`define XMIA_CLK_MHZ 100
`define XMIA_RECOG_US 128
`define XMIA_RECOG_CYC (`XMIA_RECOG_US * `XMIA_CLK_MHZ)

`endif

/* xmia_pkg.sv */
/*
 * Types shared by the extended access window modules.
 * Assumes xmia_defs.svh is on the include path.
 */
package xmia_pkg;

   // ==========================================================
   // sequencer states
   typedef enum logic [1:0] {
      XMIA_IDLE,
      XMIA_WAIT_SLOT,
      XMIA_ISSUE,
      XMIA_WAIT_DONE
   } xmia_state_e;

   typedef logic [7:0] xmia_byte_t;

endpackage

/* xmia_sync.sv */
/*
 * Two-flop synchroniser for a level from outside the clock domain.
 * Assumes the level is slow compared to the clock.
 */
`timescale 1ns/1ps
module xmia_sync
   import xmia_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // level
   input wire logic d_in,
   output logic q_out
);
   typedef struct packed {
      logic s1_ff;
      logic s2_ff;
   } xmia_sync_s;

   xmia_sync_s st_ff;
   xmia_sync_s nxt_st;

   always_comb begin
      nxt_st.s1_ff = d_in;
      nxt_st.s2_ff = st_ff.s1_ff;
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q_out = st_ff.s2_ff;
endmodule

/* xmia_seq.sv */
/*
 * Command sequencer: waits for a processor slot, issues one extended
 * command, waits for the processor to finish and pulses done.
 * Assumes slot and finish levels are already synchronised.
 */
`timescale 1ns/1ps
`include "xmia_defs.svh"
module xmia_seq
   import xmia_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // request from register bank
   input wire logic start_in,
   output logic busy_out,
   output logic done_out,
   output logic timeout_out,
   // processor side
   input wire logic slot_in,
   input wire logic finish_in,
   output logic issue_out
);
   typedef struct packed {
      xmia_state_e state_ff;
      logic [13:0] wait_ff;
      logic done_ff;
      logic timeout_ff;
   } xmia_seq_s;

   localparam logic [13:0] RECOG_CYC = 14'(`XMIA_RECOG_CYC);

   xmia_seq_s st_ff;
   xmia_seq_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.done_ff = 1'b0;
      nxt_st.timeout_ff = 1'b0;
      unique case (st_ff.state_ff)
         XMIA_IDLE: begin
            if (start_in) begin
               nxt_st.state_ff = XMIA_WAIT_SLOT;
               nxt_st.wait_ff = '0;
            end
         end
         // only between angle computations
         XMIA_WAIT_SLOT: begin
            if (slot_in) begin
               nxt_st.state_ff = XMIA_ISSUE; // R17
            end else begin
               nxt_st.wait_ff = st_ff.wait_ff + 14'h0001;
               // flag only; the command still waits its slot
               if (st_ff.wait_ff == RECOG_CYC) begin
                  nxt_st.timeout_ff = 1'b1; // R17
               end
            end
         end
         XMIA_ISSUE: begin
            nxt_st.state_ff = XMIA_WAIT_DONE;
         end
         XMIA_WAIT_DONE: begin
            if (finish_in) begin
               nxt_st.state_ff = XMIA_IDLE;
               nxt_st.done_ff = 1'b1; // R19
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         st_ff <= '{XMIA_IDLE, 14'h0000, 1'b0, 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign busy_out = (st_ff.state_ff != XMIA_IDLE);
   assign issue_out = (st_ff.state_ff == XMIA_ISSUE);
   assign done_out = st_ff.done_ff;
   assign timeout_out = st_ff.timeout_ff;
endmodule

/* xmia_checker.sv */
/* Assertions on the extended access window's top ports.
   Assumes a bind from the testbench top file, one clock domain. */
`timescale 1ns/1ps
module xmia_checker (
   // clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic NRST_IN,
   // byte port
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_RDATA_OUT,
   input wire logic REG_HIT_OUT,
   // mode and processor side
   input wire logic IDLE_MODE_IN,
   input wire logic PROC_SLOT_IN,
   input wire logic PROC_WR_CMD_OUT,
   input wire logic PROC_RD_CMD_OUT,
   input wire logic [15:0] PROC_ADDR_OUT,
   input wire logic [31:0] PROC_WDATA_OUT,
   input wire logic PROC_IDLE_OUT,
   input wire logic CMD_LATE_OUT
);
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!NRST_IN);
   // ====
   // command pulses
   sequence wr_once;
      PROC_WR_CMD_OUT ##1 !PROC_WR_CMD_OUT;
   endsequence
   sequence rd_once;
      PROC_RD_CMD_OUT ##1 !PROC_RD_CMD_OUT;
   endsequence
   wr_pulse_a: assert property (PROC_WR_CMD_OUT |-> wr_once)
      else $error("write command longer than one cycle");
   rd_pulse_a: assert property (PROC_RD_CMD_OUT |-> rd_once)
      else $error("read command longer than one cycle");
   slot_gate_a: assert property ((PROC_WR_CMD_OUT || PROC_RD_CMD_OUT)
      |-> $past(PROC_SLOT_IN, 3)) else $error("command issued without slot");
   late_pulse_a: assert property (CMD_LATE_OUT |=> !CMD_LATE_OUT)
      else $error("late flag longer than one cycle");
   // ====
   // byte port, idle level and command snapshots
   hit_range_a: assert property (REG_HIT_OUT ==
      (REG_ADDR_IN >= 8'h02 && REG_ADDR_IN <= 8'h11))
      else $error("hit flag wrong for address");
   unmapped_zero_a: assert property (REG_RD_IN && !REG_HIT_OUT
      |=> REG_RDATA_OUT == 8'h00) else $error("unmapped read not zero");
   rdata_hold_a: assert property ($past(NRST_IN) && !$past(REG_RD_IN)
      |-> $stable(REG_RDATA_OUT)) else $error("read byte moved alone");
   idle_sync_a: assert property ($past(NRST_IN) && $past(NRST_IN, 2)
      |-> PROC_IDLE_OUT == $past(IDLE_MODE_IN, 2))
      else $error("idle level not two cycles late");
   addr_snap_a: assert property ($past(NRST_IN) &&
      !$stable(PROC_ADDR_OUT) |-> $past(REG_WR_IN) &&
      ($past(REG_ADDR_IN) == 8'h08 || $past(REG_ADDR_IN) == 8'h0C))
      else $error("command address moved without trigger");
   wdata_snap_a: assert property ($past(NRST_IN) &&
      !$stable(PROC_WDATA_OUT) |-> $past(REG_WR_IN) &&
      $past(REG_ADDR_IN) == 8'h08) else $error("write data moved alone");
endmodule

/* xmia_proc_model.sv */
/* Far-side processor model: answers write and read commands.
   Assumes the bench holds stall and latency steady per command. */
`timescale 1ns/1ps
module xmia_proc_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // commands from the window
   input wire logic wr_cmd_in,
   input wire logic rd_cmd_in,
   input wire logic [15:0] addr_in,
   input wire logic [31:0] wdata_in,
   // bench control
   input wire logic stall_in,
   input wire logic [7:0] lat_in,
   // answers
   output logic slot_out,
   output logic finish_out,
   output logic [31:0] result_out
);
   logic [31:0] mem [16];
   logic [31:0] val;
   logic [8:0] cnt;
   // ====
   // stalled means inside an angle computation
   assign slot_out = !stall_in;
   // result is only good while finish is up
   assign result_out = finish_out ? val : ~val;
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         cnt <= 9'h000;
         finish_out <= 1'b0;
         val <= 32'h0000_0000;
      end else begin
         // programming pulses not modelled: the word lands at once
         if (wr_cmd_in) mem[addr_in[3:0]] <= wdata_in;
         if (rd_cmd_in) val <= mem[addr_in[3:0]];
         if (wr_cmd_in || rd_cmd_in) cnt <= {1'b0, lat_in} + 9'h004;
         else if (cnt != 9'h000) cnt <= cnt - 9'h001;
         // four cycles, longer than the synchroniser needs
         finish_out <= (cnt != 9'h000) && (cnt <= 9'h004);
      end
   end
endmodule

/* tb.sv */
/* Bench for the extended access window: register readback, write and
   read transfers, refused trigger and slot wait. Needs the model. */
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } xmia_row_s;
   logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, idle = 1'b0;
   logic stall = 1'b1, hit, slot, fin, wcmd, rcmd, idle_o, late;
   logic [7:0] addr = 8'h00, wdata = 8'h00, lat = 8'h10, rdata, got;
   logic [15:0] paddr, cap_addr;
   logic [31:0] res, pwdata, cap_data;
   int n_fail = 0, samples_checked = 0, n_late = 0, n_wr = 0;
   xmia_row_s rows [11] = '{'{8'h02, 8'h03, 8'h03}, '{8'h03, 8'h17, 8'h17},
      '{8'h04, 8'hA1, 8'hA1}, '{8'h05, 8'h5B, 8'h5B}, '{8'h06, 8'hC3, 8'hC3},
      '{8'h07, 8'h3C, 8'h3C}, '{8'h0A, 8'h7E, 8'h7E}, '{8'h0B, 8'h81, 8'h81},
      '{8'h00, 8'hFF, 8'h00}, '{8'h12, 8'hFF, 8'h00}, '{8'h0E, 8'hFF, 8'h00}};
   logic [15:0] wseq [7] = '{16'h0203, 16'h0317, 16'h0400, 16'h0512,
      16'h0630, 16'h0783, 16'h0880};
   logic [15:0] rseq [3] = '{16'h0A03, 16'h0B17, 16'h0C80};
   always #5 clk = ~clk;
   xmia_top i_dut (.CLK_SYS_IN(clk), .NRST_IN(nrst), .REG_WR_IN(wr),
      .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_RDATA_OUT(rdata), .REG_HIT_OUT(hit), .IDLE_MODE_IN(idle),
      .PROC_SLOT_IN(slot), .PROC_FINISH_IN(fin), .PROC_RESULT_IN(res),
      .PROC_WR_CMD_OUT(wcmd), .PROC_RD_CMD_OUT(rcmd), .PROC_ADDR_OUT(paddr),
      .PROC_WDATA_OUT(pwdata), .PROC_IDLE_OUT(idle_o), .CMD_LATE_OUT(late));
   xmia_proc_model i_proc (.clk_in(clk), .nrst_in(nrst), .wr_cmd_in(wcmd),
      .rd_cmd_in(rcmd), .addr_in(paddr), .wdata_in(pwdata), .stall_in(stall),
      .lat_in(lat), .slot_out(slot), .finish_out(fin), .result_out(res));
   // ====
   // bus tasks, inputs move 1 ns after the edge
   task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1;
      wr = 1'b0;
   endtask
   task automatic rd_b(input logic [7:0] a);
      @(posedge clk);
      #1;
      rd = 1'b1;
      addr = a;
      @(posedge clk);
      #1;
      rd = 1'b0;
      got = rdata;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic poll(input logic [7:0] a);
      int k;
      k = 0;
      got = 8'h00;
      while (got[0] !== 1'b1 && k < 100) begin
         rd_b(a);
         k++;
      end
      chk(32'(got), 32'h01);
   endtask
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // mid-cycle sampling keeps clear of edge races
   always @(negedge clk) begin
      if (wcmd === 1'b1) begin
         cap_addr = paddr;
         cap_data = pwdata;
         n_wr++;
      end
      if (late === 1'b1) n_late++;
   end
   initial begin
      #300000;
      n_fail++;
      end_sim;
   end
   // ====
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      #1;
      nrst = 1'b1;
      foreach (rows[i]) begin
         wr_b(rows[i].a, rows[i].d);
         rd_b(rows[i].a);
         chk(32'(got), 32'(rows[i].e));
      end
      nrst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      nrst = 1'b1;
      rd_b(8'h02);
      chk(32'(got), 32'h00);
      stall = 1'b0;
      idle = 1'b1;
      foreach (wseq[i]) wr_b(wseq[i][15:8], wseq[i][7:0]);
      rd_b(8'h09);
      chk(32'(got), 32'h00);
      rd_b(8'h08);
      chk(32'(got), 32'h80);
      poll(8'h09);
      chk(32'(cap_addr), 32'h0317);
      chk(cap_data, 32'h0012_3083);
      lat = 8'h00;
      foreach (rseq[i]) wr_b(rseq[i][15:8], rseq[i][7:0]);
      rd_b(8'h0D);
      chk(32'(got), 32'h00);
      rd_b(8'h0C);
      chk(32'(got), 32'h80);
      poll(8'h0D);
      for (int i = 0; i < 4; i++) begin
         rd_b(8'(8'h0E + i));
         chk(32'(got), (32'h0012_3083 >> (24 - 8 * i)) & 32'hFF);
      end
      stall = 1'b1;
      wr_b(8'h03, 8'h06);
      wr_b(8'h08, 8'h80);
      rd_b(8'h09);
      chk(32'(got), 32'h00);
      wr_b(8'h03, 8'h09);
      wr_b(8'h08, 8'h80);
      repeat (13000) @(posedge clk);
      chk(32'(n_late), 32'h1);
      #1;
      stall = 1'b0;
      poll(8'h09);
      chk(32'(cap_addr), 32'h0306);
      chk(32'(n_wr), 32'h2);
      end_sim;
   end
endmodule
bind xmia_top xmia_checker i_chk (.CLK_SYS_IN(CLK_SYS_IN),
   .NRST_IN(NRST_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
   .REG_ADDR_IN(REG_ADDR_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
   .REG_HIT_OUT(REG_HIT_OUT), .IDLE_MODE_IN(IDLE_MODE_IN),
   .PROC_SLOT_IN(PROC_SLOT_IN), .PROC_WR_CMD_OUT(PROC_WR_CMD_OUT),
   .PROC_RD_CMD_OUT(PROC_RD_CMD_OUT), .PROC_ADDR_OUT(PROC_ADDR_OUT),
   .PROC_WDATA_OUT(PROC_WDATA_OUT), .PROC_IDLE_OUT(PROC_IDLE_OUT),
   .CMD_LATE_OUT(CMD_LATE_OUT));
